/* File: design/cdb_clock_divider.sv */
// Notes on behaviour
// RULE1 - divide by 2 or 4n gives 50% duty
// RULE2 - other even dividers give tabulated lower duty
// RULE3 - inverted output gives complemented duty
// RULE4 - all outputs start edge aligned after reset
// RULE5 - divide by 2, skew over 8 may runt
// RULE6 - otherwise only complete cycles from start
// RULE7 - bypass feeds input divider into output dividers
// RULE8 - bypass halves output divider, ratios 1 to 32
// RULE9 - bypass drops lock indication and skew
// RULE10 - reference choice 0 selects A, 1 B
// RULE11 - feedback choice 0 selects A, 1 B
// RULE12 - single pair variant has no selection
// RULE13 - 1.8V CMOS receiver setting is distinct
// RULE14 - output dividers take even 2 to 64
// RULE15 - loop mode runs dividers at oscillator rate
// RULE16 - input divider 1 to 32 prescales reference
// RULE17 - bypass output is ref over M over V/2
// RULE18 - odd-half dividers stay high V/2 minus 1
`default_nettype none
`include "cdb_regs.svh"

module cdb_clock_divider (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire cdb_pkg::cdb_cfg_t cfg_i,
  input wire logic reference_pair_a_i,
  input wire logic reference_pair_b_i,
  input wire logic feedback_pair_a_i,
  input wire logic feedback_pair_b_i,
  input wire logic reference_pair_choice_i,
  input wire logic feedback_pair_choice_i,
  input wire logic single_pair_i,
  input wire logic bypass_i,
  input wire logic pll_locked_i,
  output logic [`CDB_NUM_OUT-1:0] clk_out_o,
  output logic lock_o,
  output logic ref_sel_o,
  output logic fbk_sel_o,
  output logic ref_divided_o,
  output logic fbk_level_o,
  output logic rx_low_threshold_o
);

  // output period in ticks for a divider code
  function automatic logic [`CDB_CNT_W-1:0] period_f(
    input logic [`CDB_CODE_W-1:0] code,
    input logic byp
  );
    logic [`CDB_CNT_W-1:0] r;
    r = {2'h0, code} + 7'h01;
    period_f = byp ? r : {r[`CDB_CNT_W-2:0], 1'b0};
  endfunction

  // ticks that the output stays high within one period
  function automatic logic [`CDB_CNT_W-1:0] high_f(
    input logic [`CDB_CODE_W-1:0] code,
    input logic byp
  );
    logic [`CDB_CNT_W-1:0] p;
    logic [`CDB_CNT_W-1:0] h;
    p = period_f(code, byp);
    h = {1'b0, p[`CDB_CNT_W-1:1]};
    if (byp || p == 7'h02 || p[1:0] == 2'h0)
      high_f = h;
    else
      high_f = h - 7'h01;
  endfunction

  cdb_pkg::cdb_pins_t pins_raw;
  cdb_pkg::cdb_pins_t sync1_q;
  cdb_pkg::cdb_pins_t pin_q;
  cdb_pkg::cdb_cfg_t cfg_q;
  logic bypass_q;
  logic restart_q;
  logic restart_d;
  logic ref_prev_q;
  logic ref_lvl;
  logic ref_rise;
  logic [`CDB_CODE_W-1:0] mcnt_q;
  logic [`CDB_CODE_W-1:0] mcnt_d;
  logic mdiv_q;
  logic mdiv_d;
  logic mdiv_prev_q;
  logic [`CDB_CODE_W:0] mhalf_w;
  logic tick;
  logic sel_ref_b;
  logic sel_fbk_b;
  cdb_pkg::cdb_ch_state_t st_q [`CDB_NUM_OUT];
  cdb_pkg::cdb_ch_state_t st_d [`CDB_NUM_OUT];
  logic [`CDB_CNT_W-1:0] cnt_q [`CDB_NUM_OUT];
  logic [`CDB_CNT_W-1:0] cnt_d [`CDB_NUM_OUT];
  logic [`CDB_SKEW_W-1:0] dly_q [`CDB_NUM_OUT];
  logic [`CDB_SKEW_W-1:0] dly_d [`CDB_NUM_OUT];
  logic [`CDB_NUM_OUT-1:0] raw_w;
  logic [`CDB_NUM_OUT-1:0] out_d;

  // pin group into the synchroniser
  assign pins_raw = '{ref_a: reference_pair_a_i,
                      ref_b: reference_pair_b_i,
                      fbk_a: feedback_pair_a_i,
                      fbk_b: feedback_pair_b_i,
                      ref_choice: reference_pair_choice_i,
                      fbk_choice: feedback_pair_choice_i,
                      single_pair: single_pair_i,
                      bypass: bypass_i,
                      locked: pll_locked_i};

  // two-flop synchroniser for all pins
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      sync1_q <= pins_raw;
      pin_q <= sync1_q;
    end
  end

  // pair selection; the single-pair variant ignores the choice pins
  assign sel_ref_b = pin_q.ref_choice & ~pin_q.single_pair; // RULE10 RULE12
  assign sel_fbk_b = pin_q.fbk_choice & ~pin_q.single_pair; // RULE11 RULE12
  assign ref_lvl = sel_ref_b ? pin_q.ref_b : pin_q.ref_a;
  assign ref_rise = ref_lvl & ~ref_prev_q;

  // input divider: period of code+1 reference cycles
  assign mcnt_d = ref_rise ? ((mcnt_q == cfg_q.mdiv_code) ? `CDB_MCNT_RST
                  : mcnt_q + 5'h01) : mcnt_q; // RULE16
  // high half one bit wider, so that M of 32 does not wrap to zero
  assign mhalf_w = ({1'b0, cfg_q.mdiv_code} + 6'h01) >> 1;
  assign mdiv_d = (cfg_q.mdiv_code == 5'h00) ? ref_lvl
                  : ({1'b0, mcnt_q} < mhalf_w); // RULE16

  // loop mode: core clock stands for the oscillator; bypass: divided ref
  assign tick = bypass_q ? (mdiv_q & ~mdiv_prev_q) : 1'b1; // RULE7 RULE15

  // any change of setup or mode realigns every output
  assign restart_d = (cfg_i != cfg_q) | (pin_q.bypass != bypass_q); // RULE4

  // input divider, mode and setup registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_q <= '0;
      bypass_q <= 1'b0;
      restart_q <= 1'b0;
      ref_prev_q <= 1'b0;
      mcnt_q <= `CDB_MCNT_RST;
      mdiv_q <= 1'b0;
      mdiv_prev_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_i;
      bypass_q <= pin_q.bypass;
      restart_q <= restart_d;
      ref_prev_q <= ref_lvl;
      mcnt_q <= mcnt_d;
      mdiv_q <= mdiv_d;
      mdiv_prev_q <= mdiv_q;
    end
  end

  // output divider channels
  for (genvar k = 0; k < `CDB_NUM_OUT; k++)
  begin : g_ch
    logic [`CDB_CNT_W-1:0] per_w;
    logic [`CDB_CNT_W-1:0] hi_w;
    logic [`CDB_SKEW_W-1:0] skew_w;
    logic one_w;

    // code k gives 2(k+1) in loop mode and k+1 in bypass
    assign per_w = period_f(cfg_q.vdiv_code[k], bypass_q); // RULE8 RULE14
    assign hi_w = high_f(cfg_q.vdiv_code[k], bypass_q); // RULE1 RULE2 RULE18
    assign skew_w = bypass_q ? `CDB_SKEW_RST : cfg_q.skew[k]; // RULE9
    assign one_w = bypass_q && per_w == 7'h01;
    // bypass ratio 1 passes the divided reference straight through
    assign raw_w[k] = one_w ? mdiv_q : (cnt_q[k] < hi_w); // RULE17
    // idle level is the inactive level, so the first cycle is whole;
    // a pending restart shows it at once, new setup never meets old count
    assign out_d[k] = (st_q[k] == cdb_pkg::CDB_CH_RUN && !restart_q) ?
                      (raw_w[k] ^ cfg_q.invert[k]) : cfg_q.invert[k]; // RULE3

    // channel sequencing: idle, skew wait, run
    always_comb
    begin
      st_d[k] = st_q[k];
      cnt_d[k] = cnt_q[k];
      dly_d[k] = dly_q[k];
      case (st_q[k])
        cdb_pkg::CDB_CH_IDLE:
        begin
          st_d[k] = cdb_pkg::CDB_CH_WAIT;
          dly_d[k] = `CDB_SKEW_RST;
          cnt_d[k] = `CDB_CNT_RST;
        end
        cdb_pkg::CDB_CH_WAIT:
        begin
          // skew delays the start; a late start never cuts a cycle
          if (tick && dly_q[k] == skew_w)
            st_d[k] = cdb_pkg::CDB_CH_RUN; // RULE4 RULE5 RULE6
          else if (tick)
            dly_d[k] = dly_q[k] + 4'h1;
        end
        cdb_pkg::CDB_CH_RUN:
        begin
          if (tick)
            cnt_d[k] = (cnt_q[k] >= per_w - 7'h01) ? `CDB_CNT_RST
                       : cnt_q[k] + 7'h01;
        end
        default:
        begin
          st_d[k] = cdb_pkg::CDB_CH_IDLE;
        end
      endcase
      if (restart_q)
        st_d[k] = cdb_pkg::CDB_CH_IDLE; // RULE4
    end

    // channel state registers
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        st_q[k] <= cdb_pkg::CDB_CH_IDLE;
        cnt_q[k] <= `CDB_CNT_RST;
        dly_q[k] <= `CDB_SKEW_RST;
      end
      else
      begin
        st_q[k] <= st_d[k];
        cnt_q[k] <= cnt_d[k];
        dly_q[k] <= dly_d[k];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clk_out_o <= '0;
      lock_o <= 1'b0;
      ref_sel_o <= 1'b0;
      fbk_sel_o <= 1'b0;
      fbk_level_o <= 1'b0;
      rx_low_threshold_o <= 1'b0;
    end
    else
    begin
      clk_out_o <= out_d;
      lock_o <= pin_q.locked & ~pin_q.bypass; // RULE9
      ref_sel_o <= sel_ref_b;
      fbk_sel_o <= sel_fbk_b;
      fbk_level_o <= sel_fbk_b ? pin_q.fbk_b : pin_q.fbk_a;
      rx_low_threshold_o <= (cfg_i.rx_std == cdb_pkg::CDB_RX_LVCMOS18); // RULE13
    end
  end

  assign ref_divided_o = mdiv_q;

  // lock never shown in bypass
  property p_bypass_no_lock;
    @(posedge clk_i) disable iff (!rstn_i)
    pin_q.bypass |=> !lock_o;
  endproperty
  a_bypass_no_lock: assert property (p_bypass_no_lock) // RULE9
    else $error("lock shown in bypass");

  // reference choice follows synchronised pin
  property p_ref_sel;
    @(posedge clk_i) disable iff (!rstn_i)
    (pin_q.ref_choice && !pin_q.single_pair) |=> ref_sel_o;
  endproperty
  a_ref_sel: assert property (p_ref_sel) // RULE10
    else $error("reference pair B not selected");

  // feedback choice follows synchronised pin
  property p_fbk_sel;
    @(posedge clk_i) disable iff (!rstn_i)
    (pin_q.fbk_choice && !pin_q.single_pair) |=> fbk_sel_o;
  endproperty
  a_fbk_sel: assert property (p_fbk_sel) // RULE11
    else $error("feedback pair B not selected");

  // single pair variant always uses pair A
  property p_single;
    @(posedge clk_i) disable iff (!rstn_i)
    pin_q.single_pair |=> (!ref_sel_o && !fbk_sel_o);
  endproperty
  a_single: assert property (p_single) // RULE12
    else $error("pair B used in single pair variant");

  // 1.8V CMOS setting raises low threshold flag
  property p_rx_low;
    @(posedge clk_i) disable iff (!rstn_i)
    (cfg_i.rx_std == cdb_pkg::CDB_RX_LVCMOS18) |=> rx_low_threshold_o;
  endproperty
  a_rx_low: assert property (p_rx_low) // RULE13
    else $error("1.8V threshold flag missing");

  // divide by 4 gives two high and two low cycles
  property p_half_duty;
    @(posedge clk_i) disable iff (!rstn_i || restart_q)
    ($rose(clk_out_o[0]) && !bypass_q && cfg_q.vdiv_code[0] == 5'h01
     && !cfg_q.invert[0]) |=> clk_out_o[0] ##1 !clk_out_o[0];
  endproperty
  a_half_duty: assert property (p_half_duty) // RULE1
    else $error("divide by 4 duty not half");

  // divide by 6 gives two high and four low cycles
  property p_duty6;
    @(posedge clk_i) disable iff (!rstn_i || restart_q)
    ($rose(clk_out_o[0]) && !bypass_q && cfg_q.vdiv_code[0] == 5'h02
     && !cfg_q.invert[0]) |=> clk_out_o[0] ##1 !clk_out_o[0] [*4];
  endproperty
  a_duty6: assert property (p_duty6) // RULE2
    else $error("divide by 6 duty wrong");

  // inverted divide by 6 gives two low and four high cycles
  property p_inv6;
    @(posedge clk_i) disable iff (!rstn_i || restart_q)
    ($fell(clk_out_o[0]) && !bypass_q && cfg_q.vdiv_code[0] == 5'h02
     && cfg_q.invert[0]) |=> !clk_out_o[0] ##1 clk_out_o[0] [*4];
  endproperty
  a_inv6: assert property (p_inv6) // RULE3
    else $error("inverted divide by 6 duty wrong");

endmodule

`default_nettype wire

/* File: pkg/cdb_regs.svh */
`ifndef CDB_REGS_SVH
`define CDB_REGS_SVH

// number of output dividers and field widths
`define CDB_NUM_OUT 5
`define CDB_CODE_W 5
`define CDB_CNT_W 7
`define CDB_SKEW_W 4
`define CDB_STD_W 3

// core clock period in ns (10 MHz)
`define CDB_CLK_PERIOD_NS 100

// skew setting above which a divide-by-2 output may start with a runt
`define CDB_RUNT_SKEW_LIMIT 4'h8

// reset values
`define CDB_CNT_RST 7'h00
`define CDB_MCNT_RST 5'h00
`define CDB_SKEW_RST 4'h0

// receiver standard encodings
`define CDB_STD_LVTTL 3'h0
`define CDB_STD_LVCMOS18 3'h1
`define CDB_STD_LVCMOS25 3'h2
`define CDB_STD_LVCMOS33 3'h3
`define CDB_STD_SSTL_HSTL 3'h4
`define CDB_STD_DIFF_SSTL_HSTL 3'h5
`define CDB_STD_LVDS 3'h6
`define CDB_STD_LVPECL 3'h7

`endif

/* File: pkg/cdb_pkg.sv */
`default_nettype none
`include "cdb_regs.svh"

package cdb_pkg;

  // receiver standard selection
  typedef enum logic [`CDB_STD_W-1:0] {
    CDB_RX_LVTTL = `CDB_STD_LVTTL,
    CDB_RX_LVCMOS18 = `CDB_STD_LVCMOS18,
    CDB_RX_LVCMOS25 = `CDB_STD_LVCMOS25,
    CDB_RX_LVCMOS33 = `CDB_STD_LVCMOS33,
    CDB_RX_SSTL_HSTL = `CDB_STD_SSTL_HSTL,
    CDB_RX_DIFF_SSTL_HSTL = `CDB_STD_DIFF_SSTL_HSTL,
    CDB_RX_LVDS = `CDB_STD_LVDS,
    CDB_RX_LVPECL = `CDB_STD_LVPECL
  } cdb_rx_std_t;

  // per-output divider channel states
  typedef enum logic [2:0] {
    CDB_CH_IDLE = 3'b001,
    CDB_CH_WAIT = 3'b010,
    CDB_CH_RUN = 3'b100
  } cdb_ch_state_t;

  // static configuration, same clock domain as the block
  typedef struct packed {
    cdb_rx_std_t rx_std;
    logic [`CDB_CODE_W-1:0] mdiv_code;
    logic [`CDB_NUM_OUT-1:0][`CDB_CODE_W-1:0] vdiv_code;
    logic [`CDB_NUM_OUT-1:0] invert;
    logic [`CDB_NUM_OUT-1:0][`CDB_SKEW_W-1:0] skew;
  } cdb_cfg_t;

  // asynchronous pin inputs, synchronised as one group
  typedef struct packed {
    logic ref_a;
    logic ref_b;
    logic fbk_a;
    logic fbk_b;
    logic ref_choice;
    logic fbk_choice;
    logic single_pair;
    logic bypass;
    logic locked;
  } cdb_pins_t;

endpackage

`default_nettype wire

/* File: tb/cdb_board_model.sv */
`default_nettype none

module cdb_board_model (
  input wire logic [4:0] clk_out_i,
  output logic ref_a_o,
  output logic ref_b_o,
  output logic fbk_a_o,
  output logic fbk_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // two free-running board references, kept off the core clock edges
  initial
  begin
    ref_a_o = 1'b0;
    ref_b_o = 1'b0;
    #7;
    fork
      forever #400 ref_a_o = ~ref_a_o;
      forever #600 ref_b_o = ~ref_b_o;
    join
  end

  // clocked loads hand two outputs back as external feedback
  assign fbk_a_o = clk_out_i[0];
  assign fbk_b_o = clk_out_i[1];
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`include "cdb_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i;
  logic rstn_i;
  cdb_pkg::cdb_cfg_t cfg;
  logic ref_choice, fbk_choice, single_pair, bypass, locked;
  logic ref_a, ref_b, fbk_a, fbk_b, lock, ref_sel, fbk_sel, rx_low;
  logic [`CDB_NUM_OUT-1:0] clk_out;
  logic [`CDB_NUM_OUT-1:0] idle;
  logic [`CDB_NUM_OUT-1:0] prev;
  logic ref_div, fbk_lvl;
  int fails, n_checks, hi, per, n, v;
  int codes [2][5] = '{'{2, 1, 0, 4, 6}, '{31, 15, 29, 17, 20}};

  cdb_clock_divider dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
    .reference_pair_a_i(ref_a), .reference_pair_b_i(ref_b),
    .feedback_pair_a_i(fbk_a), .feedback_pair_b_i(fbk_b),
    .reference_pair_choice_i(ref_choice),
    .feedback_pair_choice_i(fbk_choice), .single_pair_i(single_pair),
    .bypass_i(bypass), .pll_locked_i(locked), .clk_out_o(clk_out),
    .lock_o(lock), .ref_sel_o(ref_sel), .fbk_sel_o(fbk_sel),
    .ref_divided_o(ref_div), .fbk_level_o(fbk_lvl),
    .rx_low_threshold_o(rx_low)
  );

  cdb_board_model board (
    .clk_out_i(clk_out), .ref_a_o(ref_a), .ref_b_o(ref_b),
    .fbk_a_o(fbk_a), .fbk_b_o(fbk_b)
  );

  // core clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int c);
    repeat (c) @(negedge clk_i);
  endtask

  // bounded wait for one output bit to reach a level
  task automatic wait_bit(input int k, input logic lv);
    int w;
    w = 0;
    while (clk_out[k] !== lv)
    begin
      @(negedge clk_i);
      w++;
      if (w > 3000)
      begin
        fails++;
        wrap_up();
      end
    end
  endtask

  // high time and period of one output, in core cycles
  task automatic measure(input int k);
    wait_bit(k, 1'b0);
    wait_bit(k, 1'b1);
    hi = 0;
    while (clk_out[k] === 1'b1 && hi < 3000)
    begin
      @(negedge clk_i);
      hi++;
    end
    per = hi;
    while (clk_out[k] === 1'b0 && per < 3000)
    begin
      @(negedge clk_i);
      per++;
    end
  endtask

  // high cycles of the input divider output over c core cycles
  task automatic count_div(input int c);
    n = 0;
    repeat (c)
    begin
      @(negedge clk_i);
      n += ref_div;
    end
  endtask

  function automatic int exp_hi(input int vv);
    return (vv == 2 || vv % 4 == 0) ? vv / 2 : vv / 2 - 1;
  endfunction

  initial
  begin
    fails = 0;
    n_checks = 0;
    rstn_i = 1'b0;
    cfg = '0;
    ref_choice = 1'b0;
    fbk_choice = 1'b0;
    single_pair = 1'b0;
    bypass = 1'b0;
    locked = 1'b0;
    settle(20);
    rstn_i = 1'b1;
    // loop mode duty, period, inversion and aligned start
    for (int s = 0; s < 2; s++)
      for (int inv = 0; inv < 2; inv++)
      begin
        idle = inv ? 5'h1F : 5'h00;
        for (int k = 0; k < 5; k++)
          cfg.vdiv_code[k] = codes[s][k];
        cfg.invert = idle;
        settle(4);
        n = 0;
        while (clk_out === idle && n < 3000)
        begin
          @(negedge clk_i);
          n++;
        end
        chk(clk_out, idle ^ 5'h1F);
        for (int k = 0; k < 5; k++)
        begin
          v = 2 * (codes[s][k] + 1);
          measure(k);
          chk(per, v);
          chk(hi, inv ? v - exp_hi(v) : exp_hi(v));
        end
      end
    // divide by 2 with a large skew starts late but whole
    cfg = '0;
    cfg.skew[0] = 4'h9;
    settle(4);
    wait_bit(1, 1'b1);
    n = 0;
    while (clk_out[0] !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n, 9);
    hi = 0;
    while (clk_out[0] === 1'b1 && hi < 3000)
    begin
      @(negedge clk_i);
      hi++;
    end
    chk(hi, 1);
    // lock follows the loop outside bypass
    locked = 1'b1;
    settle(4);
    chk(lock, 1);
    // bypass: reference over M over halved V, no lock, no skew
    bypass = 1'b1;
    cfg.mdiv_code = 5'h01;
    cfg.vdiv_code[0] = 5'h01;
    cfg.vdiv_code[1] = 5'h00;
    cfg.skew = {5{4'h5}};
    settle(4);
    chk(lock, 0);
    measure(0);
    chk(per, 32);
    measure(1);
    chk(per, 16);
    count_div(32);
    chk(n, 16);
    ref_choice = 1'b1;
    settle(4);
    measure(1);
    measure(1);
    chk(per, 24);
    // largest input divider, 32 reference cycles per period
    ref_choice = 1'b0;
    cfg.mdiv_code = 5'h1F;
    settle(20);
    count_div(256);
    chk(n, 128);
    bypass = 1'b0;
    locked = 1'b0;
    // pair selection and the small variant
    for (int i = 0; i < 8; i++)
    begin
      {single_pair, fbk_choice, ref_choice} = i[2:0];
      settle(4);
      chk(ref_sel, ref_choice & ~single_pair);
      chk(fbk_sel, fbk_choice & ~single_pair);
      prev = clk_out;
      settle(3);
      chk(fbk_lvl, (fbk_choice & ~single_pair) ? prev[1] : prev[0]);
    end
    chk(lock, 0);
    // receiver standard codes
    for (int i = 0; i < 8; i++)
    begin
      cfg.rx_std = cdb_pkg::cdb_rx_std_t'(i[2:0]);
      settle(2);
      chk(rx_low, i == 1);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
